// ===== rtl/tlic_top.sv
// Two-level interrupt controller: registers, masking, arbitration, dispatch.
// Assumes a byte register port with read data one cycle late and a CPU
// that pulses cpu_ack_i while a request is offered.
`timescale 1ns/10ps
`default_nettype none
module tlic_top
	import tlic_pkg::*;
(
	// Clock and reset.
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             hw_standby_i,
	// Register port.
	input  wire logic [15:0]      reg_addr_i,
	input  wire logic [7:0]       reg_wdata_i,
	input  wire logic             reg_we_i,
	input  wire logic             reg_re_i,
	output logic      [7:0]       reg_rdata_o,
	// Interrupt pins.
	input  wire logic             nmi_i,
	input  wire logic [EXT_N-1:0] ext_request_b_i,
	// Internal peripheral requests, held high until served.
	input  wire logic [INT_N-1:0] int_req_i,
	// Condition code mask bits from the CPU.
	input  wire logic             ccr_mask_i,
	input  wire logic             ccr_user_i,
	// CPU request and vector.
	input  wire logic             cpu_ack_i,
	output logic                  cpu_req_o,
	output logic      [7:0]       cpu_vec_o,
	output logic                  user_bit_role_select_o,
	// Event interrupt.
	output logic                  evt_irq_o
);
	import tlic_pkg::*;

	typedef struct packed {
		logic [7:0]       system_control;
		logic [7:0]       request_sense_select;
		logic [7:0]       request_enable;
		logic [7:0]       priority_level_a;
		logic [7:0]       priority_level_b;
		logic [EXT_N-1:0] flag_armed;
		logic [7:0]       evt_status;
		logic [7:0]       evt_mask;
		logic [7:0]       rdata;
		logic             nmi_prev;
		logic             nmi_primed;
		logic             nmi_pend;
		tlic_disp_e       disp;
		logic [7:0]       vec;
	} tlic_state_s;

	tlic_state_s s_reg;
	tlic_state_s s_next;

	// Signals to and from the pin sensing block.
	logic [EXT_N-1:0] ext_flag;
	logic             ext_new_set;
	logic [EXT_N-1:0] ext_sw_clr;
	logic [EXT_N-1:0] ext_ack_clr;

	// Arbitration results.
	logic [15:0] prio_bits;
	logic        pass_hi;
	logic        pass_lo;
	logic        win_valid;
	logic [7:0]  win_vec;
	logic        nmi_edge;
	logic        taken;

	// Register port decode.
	logic wr_flags;
	logic rd_flags;
	logic rd_evt;

	// External pin sensing and flags.
	tlic_ext_sense u_sense (
		.clk_i        (clk_i),
		.rst_b_i      (rst_b_i),
		.hw_standby_i (hw_standby_i),
		.pin_b_i      (ext_request_b_i),
		.sense_i      (s_reg.request_sense_select[EXT_N-1:0]),
		.sw_clr_i     (ext_sw_clr),
		.ack_clr_i    (ext_ack_clr),
		.flag_o       (ext_flag),
		.new_set_o    (ext_new_set)
	);

	// Strobes that touch the flag and event registers.
	always_comb begin
		wr_flags = reg_we_i && (reg_addr_i == ADDR_FLAGS);
		rd_flags = reg_re_i && (reg_addr_i == ADDR_FLAGS);
		rd_evt = reg_re_i && (reg_addr_i == ADDR_EVT_STAT);
	end

	// Zero written to an armed flag clears it; a written one is ignored.
	always_comb begin
		ext_sw_clr = '0;
		if (wr_flags) begin
			ext_sw_clr = ~reg_wdata_i[EXT_N-1:0] & s_reg.flag_armed;
		end
	end

	// Masking state from the two condition code bits.
	always_comb begin
		prio_bits = {s_reg.priority_level_b, s_reg.priority_level_a};
		if (!ccr_mask_i) begin
			pass_hi = 1'b1;
			pass_lo = 1'b1;
		end else if (s_reg.system_control[SYSCTL_UE_BIT]) begin
			pass_hi = 1'b0;
			pass_lo = 1'b0;
		end else begin
			pass_hi = ~ccr_user_i;
			pass_lo = 1'b0;
		end
	end

	// Nonmaskable edge in the selected direction.
	always_comb begin
		if (s_reg.system_control[SYSCTL_NONMASKABLE_EDGE_SELECT_BIT]) begin
			nmi_edge = s_reg.nmi_primed & ~s_reg.nmi_prev & nmi_i;
		end else begin
			nmi_edge = s_reg.nmi_primed & s_reg.nmi_prev & ~nmi_i;
		end
	end

	// Winner search: nonmaskable first, then high level, then low level,
	// each time the lowest vector number, since the scan rises in vector order.
	always_comb begin
		logic       hi_found;
		logic       lo_found;
		logic [7:0] hi_vec;
		logic [7:0] lo_vec;
		logic       req;
		logic       lvl;
		hi_found = 1'b0;
		lo_found = 1'b0;
		hi_vec = 8'h00;
		lo_vec = 8'h00;
		req = 1'b0;
		lvl = 1'b0;
		for (int n = 0; n < EXT_N; n++) begin
			req = ext_flag[n] & s_reg.request_enable[n];
			lvl = s_reg.priority_level_a[EXT_PRIO_BIT[n]];
			if (req && lvl && pass_hi && !hi_found) begin
				hi_found = 1'b1;
				hi_vec = VEC_EXT0 + 8'(n);
			end
			if (req && !lvl && pass_lo && !lo_found) begin
				lo_found = 1'b1;
				lo_vec = VEC_EXT0 + 8'(n);
			end
		end
		for (int i = 0; i < INT_N; i++) begin
			req = int_req_i[i];
			lvl = prio_bits[INT_PRIO[i]];
			if (req && lvl && pass_hi && !hi_found) begin
				hi_found = 1'b1;
				hi_vec = INT_VEC[i];
			end
			if (req && !lvl && pass_lo && !lo_found) begin
				lo_found = 1'b1;
				lo_vec = INT_VEC[i];
			end
		end
		if (s_reg.nmi_pend) begin
			win_valid = 1'b1;
			win_vec = VEC_NMI;
		end else if (hi_found) begin
			win_valid = 1'b1;
			win_vec = hi_vec;
		end else begin
			win_valid = lo_found;
			win_vec = lo_vec;
		end
	end

	// Acknowledge of the offered vector, and which edge flag it consumes.
	always_comb begin
		taken = cpu_ack_i && (s_reg.disp == TLIC_OFFER);
		ext_ack_clr = '0;
		for (int n = 0; n < EXT_N; n++) begin
			if (taken && (s_reg.vec == VEC_EXT0 + 8'(n))) begin
				ext_ack_clr[n] = 1'b1;
			end
		end
	end

	// Next state: registers, events, read data and dispatch.
	always_comb begin
		logic [7:0] evt_set;
		evt_set = 8'h00;
		s_next = s_reg;

		// Writes from software; reserved bits store but steer nothing.
		if (reg_we_i) begin
			unique case (reg_addr_i)
				ADDR_SYSCTL:   s_next.system_control = reg_wdata_i;
				ADDR_SENSE:    s_next.request_sense_select = reg_wdata_i;
				ADDR_ENABLE:   s_next.request_enable = reg_wdata_i;
				ADDR_PRIO_A:   s_next.priority_level_a = reg_wdata_i;
				ADDR_PRIO_B:   s_next.priority_level_b = reg_wdata_i;
				ADDR_EVT_MASK: s_next.evt_mask = reg_wdata_i;
				default: ;
			endcase
		end

		// A flag read arms its clear; a zero write disarms it.
		if (rd_flags) begin
			s_next.flag_armed = ext_flag;
		end else if (wr_flags) begin
			s_next.flag_armed = s_reg.flag_armed & reg_wdata_i[EXT_N-1:0];
		end

		// Read data, one cycle after the strobe; unmapped reads give zero.
		s_next.rdata = 8'h00;
		if (reg_re_i) begin
			unique case (reg_addr_i)
				ADDR_SYSCTL:   s_next.rdata = s_reg.system_control;
				ADDR_SENSE:    s_next.rdata = s_reg.request_sense_select;
				ADDR_ENABLE:   s_next.rdata = s_reg.request_enable;
				ADDR_FLAGS:    s_next.rdata = {3'h0, ext_flag};
				ADDR_PRIO_A:   s_next.rdata = s_reg.priority_level_a;
				ADDR_PRIO_B:   s_next.rdata = s_reg.priority_level_b;
				ADDR_EVT_STAT: s_next.rdata = s_reg.evt_status;
				ADDR_EVT_MASK: s_next.rdata = s_reg.evt_mask;
				default:       s_next.rdata = 8'h00;
			endcase
		end

		// Nonmaskable pending bit; a new edge beats the acknowledge.
		s_next.nmi_prev = nmi_i;
		s_next.nmi_primed = 1'b1;
		if (nmi_edge) begin
			s_next.nmi_pend = 1'b1;
		end else if (taken && (s_reg.vec == VEC_NMI)) begin
			s_next.nmi_pend = 1'b0;
		end

		// Dispatch: hold one vector steady until taken or withdrawn.
		unique case (s_reg.disp)
			TLIC_IDLE: begin
				if (win_valid) begin
					s_next.disp = TLIC_OFFER;
					s_next.vec = win_vec;
				end
			end
			TLIC_OFFER: begin
				if (taken) begin
					s_next.disp = TLIC_SETTLE;
				end else if (!win_valid || (win_vec != s_reg.vec)) begin
					s_next.disp = TLIC_IDLE;
				end
			end
			TLIC_SETTLE: begin
				s_next.disp = TLIC_IDLE;
			end
			default: begin
				s_next.disp = TLIC_IDLE;
			end
		endcase

		// Sticky events; read clears what was seen, a new set wins.
		evt_set[EVT_NMI_BIT] = nmi_edge;
		evt_set[EVT_EXT_BIT] = ext_new_set;
		evt_set[EVT_TAKEN_BIT] = taken;
		if (rd_evt) begin
			s_next.evt_status = evt_set;
		end else begin
			s_next.evt_status = s_reg.evt_status | evt_set;
		end

		// Hardware standby returns every register to its reset value except read data and the nonmaskable edge history.
		if (hw_standby_i) begin
			s_next.system_control = SYSCTL_RST;
			s_next.request_sense_select = ZERO_RST;
			s_next.request_enable = ZERO_RST;
			s_next.priority_level_a = ZERO_RST;
			s_next.priority_level_b = ZERO_RST;
			s_next.flag_armed = '0;
			s_next.evt_status = ZERO_RST;
			s_next.evt_mask = ZERO_RST;
			s_next.nmi_pend = 1'b0;
			s_next.disp = TLIC_IDLE;
			s_next.vec = 8'h00;
		end
	end

	// State register; reset loads the documented initial values.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_reg <= '0;
			s_reg.system_control <= SYSCTL_RST;
			s_reg.disp <= TLIC_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs from the state register.
	always_comb begin
		reg_rdata_o = s_reg.rdata;
		cpu_req_o = (s_reg.disp == TLIC_OFFER);
		cpu_vec_o = s_reg.vec;
		user_bit_role_select_o = s_reg.system_control[SYSCTL_UE_BIT];
		evt_irq_o = |(s_reg.evt_status & s_reg.evt_mask);
	end

endmodule // tlic_top
`default_nettype wire

// ===== rtl/tlic_pkg.sv
// Constants, types and register map of the two-level interrupt controller.
// Assumes a byte-wide register port and a CPU core that acknowledges vectors.
// Contract
// - Every source except nonmaskable can be set low or high priority per module.
// - Interrupt mask bit and user bit from condition code give three masking levels.
// - Each source hands the CPU its own distinct vector number.
// - Nonmaskable request is highest, never masked, edge direction selectable.
// - Each of five external requests chooses falling-edge or low-level sensing alone.
// - System control loads its reset value on reset and hardware standby only.
// - System control bit 3 at zero makes the user bit a second mask.
// - System control bit 2 picks nonmaskable edge: zero falling, one rising.
// - Priority bit clear means level 0, set means level 1; clear at reset.
// - Priority A bits 7,6,5,4 serve requests 0, 1, 2 with 3, and 4.
// - Priority A bit 3 serves watchdog, bits 2,1,0 timer channels 0,1,2.
// - Both priority registers are 8-bit read/write, cleared by reset and standby.
// - Sense bit n zero selects low-level sensing, one falling edge; reset zero.
// - Flag sets on low level or falling edge; cleared by zero-write, or by acknowledge when edge-sensed.
// - Enable bits 4 to 0 gate the five requests; upper bits are storage only.
// - Priority B bits 7,6,3,1 serve timer 3, timer 4, serial and converter.
package tlic_pkg;

	// Register addresses, lower 16 bits.
	localparam logic [15:0] ADDR_SYSCTL   = 16'hFFF2;
	localparam logic [15:0] ADDR_SENSE    = 16'hFFF4;
	localparam logic [15:0] ADDR_ENABLE   = 16'hFFF5;
	localparam logic [15:0] ADDR_FLAGS    = 16'hFFF6;
	localparam logic [15:0] ADDR_PRIO_A   = 16'hFFF8;
	localparam logic [15:0] ADDR_PRIO_B   = 16'hFFF9;
	localparam logic [15:0] ADDR_EVT_STAT = 16'hFFFA;
	localparam logic [15:0] ADDR_EVT_MASK = 16'hFFFB;

	// Reset values.
	localparam logic [7:0] SYSCTL_RST = 8'h0B;
	localparam logic [7:0] ZERO_RST   = 8'h00;

	// Field positions.
	localparam int unsigned SYSCTL_UE_BIT    = 3;
	localparam int unsigned SYSCTL_NONMASKABLE_EDGE_SELECT_BIT = 2;
	localparam int unsigned EVT_NMI_BIT      = 0;
	localparam int unsigned EVT_EXT_BIT      = 1;
	localparam int unsigned EVT_TAKEN_BIT    = 2;

	// Source counts.
	localparam int unsigned EXT_N = 5;
	localparam int unsigned INT_N = 21;

	// Vector numbers.
	localparam logic [7:0] VEC_NMI  = 8'h07;
	localparam logic [7:0] VEC_EXT0 = 8'h0C;

	// Priority bit of each external request, in priority level A.
	localparam int unsigned EXT_PRIO_BIT [EXT_N] = '{7, 6, 5, 5, 4};

	// Vector of each internal source, in rising order.
	localparam logic [7:0] INT_VEC [INT_N] = '{
		8'h14, 8'h18, 8'h19, 8'h1A, 8'h1C, 8'h1D, 8'h1E,
		8'h20, 8'h21, 8'h22, 8'h24, 8'h25, 8'h26, 8'h28,
		8'h29, 8'h2A, 8'h34, 8'h35, 8'h36, 8'h37, 8'h3C};

	// Priority bit of each internal source; 0-7 level A, 8-15 level B.
	localparam int unsigned INT_PRIO [INT_N] = '{
		3, 2, 2, 2, 1, 1, 1,
		0, 0, 0, 15, 15, 15, 14,
		14, 14, 11, 11, 11, 11, 9};

	// Dispatch states, Gray along idle, offer, settle.
	typedef enum logic [1:0] {
		TLIC_IDLE   = 2'h0,
		TLIC_OFFER  = 2'h1,
		TLIC_SETTLE = 2'h3
	} tlic_disp_e;

endpackage

// ===== rtl/tlic_ext_sense.sv
// Sensing and request flags of the five external maskable request pins.
// Assumes pins synchronous to clk_i and active low.
`timescale 1ns/10ps
`default_nettype none
module tlic_ext_sense
	import tlic_pkg::*;
(
	// Clock and reset.
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             hw_standby_i,
	// Pins and configuration.
	input  wire logic [EXT_N-1:0] pin_b_i,
	input  wire logic [EXT_N-1:0] sense_i,
	// Clear requests.
	input  wire logic [EXT_N-1:0] sw_clr_i,
	input  wire logic [EXT_N-1:0] ack_clr_i,
	// Flags.
	output logic      [EXT_N-1:0] flag_o,
	output logic                  new_set_o
);
	import tlic_pkg::*;

	typedef struct packed {
		logic [EXT_N-1:0] prev;
		logic             primed;
		logic [EXT_N-1:0] flag;
		logic             new_set;
	} tlic_sense_s;

	tlic_sense_s s_reg;
	tlic_sense_s s_next;

	// Flag set and clear per pin; a set in the same cycle beats a clear.
	always_comb begin
		logic set_n;
		logic clr_n;
		set_n = 1'b0;
		clr_n = 1'b0;
		s_next = s_reg;
		s_next.prev = pin_b_i;
		s_next.primed = 1'b1;
		s_next.new_set = 1'b0;
		for (int n = 0; n < EXT_N; n++) begin
			if (sense_i[n]) begin
				set_n = s_reg.primed & s_reg.prev[n] & ~pin_b_i[n];
			end else begin
				set_n = ~pin_b_i[n];
			end
			clr_n = sw_clr_i[n] | (ack_clr_i[n] & sense_i[n]);
			if (set_n) begin
				s_next.flag[n] = 1'b1;
				if (!s_reg.flag[n]) begin
					s_next.new_set = 1'b1;
				end
			end else if (clr_n) begin
				s_next.flag[n] = 1'b0;
			end
		end
		if (hw_standby_i) begin
			s_next = '0;
		end
	end

	// State register.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign flag_o = s_reg.flag;
	assign new_set_o = s_reg.new_set;

endmodule // tlic_ext_sense
`default_nettype wire

// ===== bench/tlic_checker.sv
// Port checker for the interrupt controller top module.
// Assumes it is bound to tlic_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module tlic_checker
	import tlic_pkg::*;
(
	// Clock and reset.
	input wire logic        clk_i,
	input wire logic        rst_b_i,
	input wire logic        hw_standby_i,
	// Register port.
	input wire logic [15:0] reg_addr_i,
	input wire logic        reg_re_i,
	input wire logic [7:0]  reg_rdata_o,
	// CPU side.
	input wire logic        ccr_mask_i,
	input wire logic        ccr_user_i,
	input wire logic        cpu_ack_i,
	input wire logic        cpu_req_o,
	input wire logic [7:0]  cpu_vec_o,
	input wire logic        user_bit_role_select_o,
	input wire logic        evt_irq_o
);
	// All checks share the one clock and its reset.
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// An accepted offer, and the two quiet cycles that must follow it.
	sequence s_take;
		cpu_req_o && cpu_ack_i;
	endsequence
	sequence s_gap;
		!cpu_req_o ##1 !cpu_req_o;
	endsequence
	// Read data stand only in the cycle after a read strobe.
	a_rdata_idle_zero: assert property (!$past(reg_re_i) |-> reg_rdata_o == 8'h00)
		else $error("read data not zero outside a read");
	a_unmapped_reads_zero: assert property ($past(reg_re_i) && ($past(reg_addr_i) inside {16'hFFF3, 16'hFFF7})
		|-> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
	a_flags_upper_zero: assert property ($past(reg_re_i) && $past(reg_addr_i) == ADDR_FLAGS
		|-> reg_rdata_o[7:5] == 3'h0) else $error("reserved flag bits not zero");
	a_reset_values: assert property (!$past(rst_b_i) |-> user_bit_role_select_o && !cpu_req_o && !evt_irq_o)
		else $error("wrong values after reset");
	a_standby_values: assert property ($past(hw_standby_i) |-> user_bit_role_select_o && !cpu_req_o)
		else $error("wrong values after hardware standby");
	a_vec_stays_put: assert property (cpu_req_o && $past(cpu_req_o) |-> $stable(cpu_vec_o))
		else $error("vector changed while offered");
	a_ack_then_gap: assert property (s_take |=> s_gap)
		else $error("offer not withdrawn after acknowledge");
	a_mask_only_nmi: assert property ($rose(cpu_req_o) && $past(ccr_mask_i)
		&& ($past(user_bit_role_select_o) || $past(ccr_user_i)) |-> cpu_vec_o == VEC_NMI)
		else $error("maskable request passed a full mask");
endmodule // tlic_checker

bind tlic_top tlic_checker u_chk (.clk_i, .rst_b_i, .hw_standby_i, .reg_addr_i, .reg_re_i, .reg_rdata_o,
	.ccr_mask_i, .ccr_user_i, .cpu_ack_i, .cpu_req_o, .cpu_vec_o, .user_bit_role_select_o, .evt_irq_o);
`default_nettype wire

// ===== bench/tlic_cpu_model.sv
// CPU core stand-in: acknowledges each standing offer after a settable lag.
// Assumes the offer holds until acknowledged or withdrawn by the controller.
`timescale 1ns/10ps
`default_nettype none
module tlic_cpu_model (
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	// Offer from the controller.
	input  wire logic       req_i,
	input  wire logic [7:0] vec_i,
	input  wire logic [3:0] lag_i,
	// Acknowledge and record of taken vectors.
	output logic            ack_o,
	output logic            taken_o,
	output logic [7:0]      vec_o,
	output logic [7:0]      count_o
);
	logic [3:0] wait_reg;
	// Counts cycles of a standing offer, then pulses ack for one cycle and logs the vector.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_o    <= 1'b0;
			taken_o  <= 1'b0;
			vec_o    <= 8'h00;
			count_o  <= 8'h00;
			wait_reg <= 4'h0;
		end else begin
			ack_o   <= 1'b0;
			taken_o <= ack_o && req_i;
			if (ack_o && req_i) begin
				vec_o   <= vec_i;
				count_o <= count_o + 8'h01;
			end
			if (!req_i || ack_o) begin
				wait_reg <= 4'h0;
			end else if (wait_reg == lag_i) begin
				ack_o <= 1'b1;
			end else begin
				wait_reg <= wait_reg + 4'h1;
			end
		end
	end
endmodule // tlic_cpu_model
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the interrupt controller top with a CPU stand-in.
// Assumes the register map and vector numbers of tlic_pkg.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import tlic_pkg::*;
	// Design inputs driven by the bench.
	logic             clk_i, rst_b_i, hw_standby_i, reg_we_i, reg_re_i, nmi_i, ccr_mask_i, ccr_user_i;
	logic [15:0]      reg_addr_i;
	logic [7:0]       reg_wdata_i;
	logic [EXT_N-1:0] ext_request_b_i;
	logic [INT_N-1:0] int_req_i;
	logic [3:0]       lag;
	// Design and stand-in outputs, scratch values and counters.
	logic [7:0]       reg_rdata_o, cpu_vec_o, tvec, tcnt, d, c0;
	logic             cpu_req_o, cpu_ack_i, evt_irq_o, taken, ube;
	int               fails, check_count, cyc;
	localparam logic [15:0] RA [7] = '{16'hFFF2, 16'hFFF4, 16'hFFF5, 16'hFFF6, 16'hFFF8, 16'hFFF9, 16'hFFF3};
	localparam logic [7:0]  RV [7] = '{8'h0B, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [15:0] WA [4] = '{16'hFFF4, 16'hFFF5, 16'hFFF8, 16'hFFF9};

	tlic_top dut (.clk_i, .rst_b_i, .hw_standby_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o,
		.nmi_i, .ext_request_b_i, .int_req_i, .ccr_mask_i, .ccr_user_i, .cpu_ack_i, .cpu_req_o, .cpu_vec_o,
		.user_bit_role_select_o(ube), .evt_irq_o);
	tlic_cpu_model cpu (.clk_i, .rst_b_i, .req_i(cpu_req_o), .vec_i(cpu_vec_o), .lag_i(lag), .ack_o(cpu_ack_i),
		.taken_o(taken), .vec_o(tvec), .count_o(tcnt));

	// Free-running clock of 10 ns.
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// Cuts a hang short; the tests need far fewer cycles.
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish();
		end
	end

	// Byte compare.
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t got %h expected %h", $time, g, e);
		end
	endtask

	// One-cycle register write; entered and left at a clock edge.
	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		reg_addr_i  <= a;
		reg_wdata_i <= v;
		reg_we_i    <= 1'b1;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	// One-cycle register read; data are taken in the following cycle.
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		reg_addr_i <= a;
		reg_re_i   <= 1'b1;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		#1 v = reg_rdata_o;
		@(posedge clk_i);
	endtask

	// Waits for the CPU stand-in to take a vector and compares it.
	task automatic take(input logic [7:0] e);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			#1 n++;
		end while (taken !== 1'b1 && n < 60);
		// A missing take must not pass on a stale vector from an earlier call.
		chk({7'h00, taken}, 8'h01);
		chk(tvec, e);
		@(posedge clk_i);
	endtask

	// Checks that no vector is taken for a while.
	task automatic quiet();
		#1 c0 = tcnt;
		repeat (12) @(posedge clk_i);
		#1 chk(tcnt, c0);
		@(posedge clk_i);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Main sequence of tests.
	initial begin
		{rst_b_i, hw_standby_i, reg_we_i, reg_re_i, ccr_mask_i, ccr_user_i} = '0;
		nmi_i = 1'b1;
		reg_addr_i = '0;
		reg_wdata_i = '0;
		ext_request_b_i = '1;
		int_req_i = '0;
		lag = 4'h3;
		repeat (2) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		foreach (RA[i]) begin
			rd(RA[i], d);
			chk(d, RV[i]);
		end
		foreach (WA[i]) begin
			wr(WA[i], 8'hA5);
			rd(WA[i], d);
			chk(d, 8'hA5);
			wr(WA[i], 8'h00);
		end
		wr(ADDR_FLAGS, 8'hFF);
		rd(ADDR_FLAGS, d);
		chk(d, 8'h00);
		wr(16'hFFF3, 8'hFF);
		rd(16'hFFF3, d);
		chk(d, 8'h00);
		$display("test registers done");
		// Level request 1: offered, then cleared only by a zero written after reading one.
		wr(ADDR_ENABLE, 8'h02);
		ext_request_b_i <= 5'b11101;
		take(8'h0D);
		ccr_mask_i <= 1'b1;
		ext_request_b_i <= '1;
		wr(ADDR_FLAGS, 8'h00);
		rd(ADDR_FLAGS, d);
		chk(d, 8'h02);
		wr(ADDR_FLAGS, 8'h00);
		rd(ADDR_FLAGS, d);
		chk(d, 8'h00);
		rd(ADDR_EVT_STAT, d);
		chk(d, 8'h06);
		$display("test level request done");
		// Edge request 2: one low sample, cleared by the acknowledge, event raised.
		wr(ADDR_EVT_MASK, 8'h04);
		wr(ADDR_SENSE, 8'h04);
		wr(ADDR_ENABLE, 8'h04);
		ccr_mask_i <= 1'b0;
		ext_request_b_i <= 5'b11011;
		@(posedge clk_i);
		ext_request_b_i <= '1;
		take(8'h0E);
		chk({7'h00, evt_irq_o}, 8'h01);
		rd(ADDR_FLAGS, d);
		chk(d, 8'h00);
		rd(ADDR_EVT_STAT, d);
		chk(d, 8'h06);
		chk({7'h00, evt_irq_o}, 8'h00);
		$display("test edge request done");
		// Arbitration and levels: request 0 against the watchdog source.
		lag <= 4'h0;
		ccr_mask_i <= 1'b1;
		wr(ADDR_ENABLE, 8'h01);
		ext_request_b_i <= 5'b11110;
		int_req_i <= 21'h000001;
		ccr_mask_i <= 1'b0;
		take(8'h0C);
		ccr_mask_i <= 1'b1;
		wr(ADDR_PRIO_A, 8'h08);
		ccr_mask_i <= 1'b0;
		take(8'h14);
		int_req_i <= '0;
		ccr_mask_i <= 1'b1;
		wr(ADDR_SYSCTL, 8'h03);
		chk({7'h00, ube}, 8'h00);
		quiet();
		wr(ADDR_PRIO_A, 8'h80);
		take(8'h0C);
		ccr_user_i <= 1'b1;
		quiet();
		nmi_i <= 1'b0;
		take(VEC_NMI);
		wr(ADDR_SYSCTL, 8'h07);
		nmi_i <= 1'b1;
		take(VEC_NMI);
		nmi_i <= 1'b0;
		quiet();
		$display("test priority and masking done");
		// Hardware standby restores reset values; then the level B sources.
		hw_standby_i <= 1'b1;
		@(posedge clk_i);
		hw_standby_i <= 1'b0;
		@(posedge clk_i);
		rd(ADDR_SYSCTL, d);
		chk(d, SYSCTL_RST);
		chk({7'h00, ube}, 8'h01);
		rd(ADDR_PRIO_A, d);
		chk(d, 8'h00);
		{ccr_mask_i, ccr_user_i} <= 2'b00;
		wr(ADDR_PRIO_B, 8'h08);
		int_req_i <= 21'h010400;
		take(8'h34);
		int_req_i <= 21'h000400;
		take(8'h24);
		int_req_i <= '0;
		$display("test standby and level B done");
		tally_and_finish();
	end
endmodule // tb
`default_nettype wire
